// ===== hw/pdfte_pkg.sv
/*
 Constants of the PD FIFO token engine: register indices, token codes,
 receive tags, symbol kinds and CRC constants.
 Assumes nothing of its surroundings.
*/
package pdfte_pkg;
    // ------------------------------------------------------------
    // Register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] FIFO_IDX = 8'h43;
    localparam logic [7:0] CTRL_IDX = 8'h44;
    localparam logic [7:0] STAT_IDX = 8'h45;
    localparam int CTRL_START = 0;
    localparam int CTRL_EN_PRIME = 1;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // ------------------------------------------------------------
    // Transmit tokens
    // ------------------------------------------------------------
    localparam logic [7:0] START_MASK = 8'he1;
    localparam logic [7:0] START_MATCH = 8'ha1;
    localparam logic [7:0] TOK_SYNC1 = 8'h12;
    localparam logic [7:0] TOK_SYNC2 = 8'h13;
    localparam logic [7:0] TOK_SYNC3 = 8'h1b;
    localparam logic [7:0] TOK_RST1 = 8'h15;
    localparam logic [7:0] TOK_RST2 = 8'h16;
    localparam logic [7:0] TOK_EOP = 8'h14;
    localparam logic [7:0] TOK_CRC = 8'hff;
    localparam logic [7:0] TOK_OFF = 8'hfe;
    localparam logic [2:0] PACK_TOP = 3'h4;
    // ------------------------------------------------------------
    // Receive tags, indexed by packet type
    // ------------------------------------------------------------
    localparam logic [2:0] TAG_SOP = 3'h7;
    localparam logic [2:0] TAG_PRIME = 3'h6;
    localparam logic [2:0] TAG_DPRIME = 3'h5;
    localparam logic [2:0] TAG_PDBG = 3'h4;
    localparam logic [2:0] TAG_DPDBG = 3'h3;
    // ------------------------------------------------------------
    // Line symbols and CRC
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SYM_SYNC1, SYM_SYNC2, SYM_SYNC3, SYM_RST1, SYM_RST2, SYM_EOP, SYM_DATA, SYM_CRC
    } pdfte_sym_e;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [2:0] CRC_LAST = 3'h7;
endpackage

// ===== hw/pdfte_top.sv
/*
 PD FIFO token engine: APB register port, transmit queue with token
 interpreter, and tagged receive queue.
 Assumes a line encoder that takes one symbol per tx_sym_ready handshake
 and a receiver that flags each packet start with its type.
*/
// The implementer's own choices: register access over APB and the placing of the registers.
// How it works
// RULE1: Tokens leave the transmit queue head singly; each action completes before next fetch.
// RULE2: Writes matching 101x_xxx1 are not queued; they start the transmitter.
// RULE3: Host writes exactly a1 for the inline start command.
// RULE4: Host should load the whole packet before starting.
// RULE5: Tokens 12, 13, 1b send sync one, two, three.
// RULE6: Tokens 15, 16 send reset symbol one and two.
// RULE7: Header 100nnnnn makes the next n bytes payload.
// RULE8: Host uses payload counts 2 to 30 and follows with that many bytes.
// RULE9: Payload low nibble goes out before high nibble.
// RULE10: Token ff inserts the computed CRC into the stream.
// RULE11: Token 14 sends an end-of-packet symbol.
// RULE12: Token fe switches the line driver off.
// RULE13: Receive queue holds 80 bytes, several packets back to back.
// RULE14: Plain SOP packets are tagged 111 in the top bits.
// RULE15: Prime packets tagged 110, stored only while enabled.
// RULE16: Double prime packets tagged 101, stored only while enabled.
// RULE17: Prime debug packets tagged 100, stored only while enabled.
// RULE18: Double prime debug packets tagged 011, stored only while enabled.
// RULE19: Host treats tags 010, 001, 000 as reserved.
// RULE20: FIFO register writes push transmit bytes, reads pop receive bytes.
// RULE21: Host writes reserved bits zero and ignores them on reads.
// RULE22: After driver off the transmitter idles until the next start.
// RULE23: Packet bytes follow their tag in arrival order.
`timescale 1ns/10ps
module pdfte_top #(
    parameter int TXQ_DEPTH = 64,
    parameter int RXQ_DEPTH = 80
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transmit symbol stream
    output logic tx_sym_valid,
    output logic [3:0] tx_sym_kind,
    output logic [3:0] tx_nibble,
    input wire logic tx_sym_ready,
    output logic tx_drv_en,
    // Receive packet stream
    input wire logic rx_sop_valid,
    input wire logic [2:0] rx_sop_type,
    input wire logic rx_byte_valid,
    input wire logic [7:0] rx_byte
);
    localparam int TW = $clog2(TXQ_DEPTH);
    localparam int RW = $clog2(RXQ_DEPTH);
    typedef enum logic [2:0] {TX_IDLE, TX_FETCH, TX_SYM, TX_PBYTE, TX_LO, TX_HI, TX_CRC} pdfte_tx_e;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic [4:0] ctrl_q;
    logic [31:0] rd_mux;
    wire setup = psel & ~penable;
    wire acc = psel & penable & pready_q;
    wire hit_fifo = paddr == {2'b00, pdfte_pkg::FIFO_IDX, 2'b00};
    wire hit_ctrl = paddr == {2'b00, pdfte_pkg::CTRL_IDX, 2'b00};
    wire hit_stat = paddr == {2'b00, pdfte_pkg::STAT_IDX, 2'b00};
    wire hit_any = hit_fifo | hit_ctrl | hit_stat;
    wire wr_fifo = acc & pwrite & hit_fifo;
    wire rd_fifo = acc & ~pwrite & hit_fifo;
    wire wr_ctrl = acc & pwrite & hit_ctrl;
    wire start_tok = (pwdata[7:0] & pdfte_pkg::START_MASK) == pdfte_pkg::START_MATCH;

    // ------------------------------------------------------------
    // Transmit queue
    // ------------------------------------------------------------
    logic [7:0] txq_mem [TXQ_DEPTH];
    logic [TW-1:0] txq_wr_q, txq_rd_q;
    logic [TW:0] txq_cnt_q;
    pdfte_tx_e st_q;
    wire txq_empty = txq_cnt_q == '0;
    wire txq_full = txq_cnt_q == (TW+1)'(TXQ_DEPTH);
    wire txq_push = wr_fifo & ~start_tok & ~txq_full; // [RULE2] [RULE20]
    wire txq_pop = ~txq_empty & (st_q == TX_FETCH | st_q == TX_PBYTE); // [RULE1]
    wire [7:0] head = txq_mem[txq_rd_q];
    wire start_cmd = (wr_fifo & start_tok) | (wr_ctrl & pwdata[pdfte_pkg::CTRL_START]); // [RULE2]

    always_ff @(posedge sys_clk) begin
        if (txq_push) begin
            txq_mem[txq_wr_q] <= pwdata[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            txq_wr_q <= '0;
            txq_rd_q <= '0;
            txq_cnt_q <= '0;
        end else begin
            if (txq_push) begin
                txq_wr_q <= (txq_wr_q == TW'(TXQ_DEPTH - 1)) ? '0 : txq_wr_q + 1'b1;
            end
            if (txq_pop) begin
                txq_rd_q <= (txq_rd_q == TW'(TXQ_DEPTH - 1)) ? '0 : txq_rd_q + 1'b1;
            end
            txq_cnt_q <= txq_cnt_q + (TW+1)'(txq_push) - (TW+1)'(txq_pop);
        end
    end

    // ------------------------------------------------------------
    // Token interpreter
    // ------------------------------------------------------------
    function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 4; i++) begin
            r = (r >> 1) ^ ((r[0] ^ d[i]) ? pdfte_pkg::CRC_POLY : 32'h00000000);
        end
        return r;
    endfunction

    logic start_pend_q, valid_q, drv_q;
    logic [3:0] kind_q, nib_q;
    logic [7:0] byte_q;
    logic [4:0] cnt_q;
    logic [2:0] crc_idx_q;
    logic [31:0] crc_q;
    wire [31:0] crc_out = ~crc_q;
    wire [31:0] crc_sh = crc_out >> {crc_idx_q + 3'h1, 2'b00};
    wire is_sym = head == pdfte_pkg::TOK_SYNC1 | head == pdfte_pkg::TOK_SYNC2 | head == pdfte_pkg::TOK_SYNC3
        | head == pdfte_pkg::TOK_RST1 | head == pdfte_pkg::TOK_RST2 | head == pdfte_pkg::TOK_EOP;
    logic [3:0] sym_kind;
    always_comb begin
        unique case (head)
            pdfte_pkg::TOK_SYNC1: sym_kind = pdfte_pkg::SYM_SYNC1; // [RULE5]
            pdfte_pkg::TOK_SYNC2: sym_kind = pdfte_pkg::SYM_SYNC2; // [RULE5]
            pdfte_pkg::TOK_SYNC3: sym_kind = pdfte_pkg::SYM_SYNC3; // [RULE5]
            pdfte_pkg::TOK_RST1: sym_kind = pdfte_pkg::SYM_RST1; // [RULE6]
            pdfte_pkg::TOK_RST2: sym_kind = pdfte_pkg::SYM_RST2; // [RULE6]
            default: sym_kind = pdfte_pkg::SYM_EOP; // [RULE11]
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            start_pend_q <= 1'b0;
        end else begin
            // A start arriving as the idle state consumes one is kept
            start_pend_q <= start_cmd | (start_pend_q & st_q != TX_IDLE);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_q <= TX_IDLE;
            valid_q <= 1'b0;
            drv_q <= 1'b0;
            kind_q <= 4'h0;
            nib_q <= 4'h0;
            byte_q <= 8'h00;
            cnt_q <= 5'h00;
            crc_idx_q <= 3'h0;
            crc_q <= pdfte_pkg::CRC_INIT;
        end else begin
            unique case (st_q)
                TX_IDLE: if (start_pend_q) begin // [RULE22]
                    st_q <= TX_FETCH;
                    drv_q <= 1'b1;
                    crc_q <= pdfte_pkg::CRC_INIT;
                end
                TX_FETCH: if (txq_pop) begin // [RULE1]
                    if (is_sym) begin
                        valid_q <= 1'b1;
                        kind_q <= sym_kind;
                        // Plain symbols carry no nibble; stale CRC data would leak out
                        nib_q <= 4'h0;
                        st_q <= TX_SYM;
                    end else if (head[7:5] == pdfte_pkg::PACK_TOP && head[4:0] != 5'h00) begin // [RULE7]
                        cnt_q <= head[4:0];
                        st_q <= TX_PBYTE;
                    end else if (head == pdfte_pkg::TOK_CRC) begin // [RULE10]
                        valid_q <= 1'b1;
                        kind_q <= pdfte_pkg::SYM_CRC;
                        nib_q <= crc_out[3:0];
                        crc_idx_q <= 3'h0;
                        st_q <= TX_CRC;
                    end else if (head == pdfte_pkg::TOK_OFF) begin // [RULE12] [RULE22]
                        drv_q <= 1'b0;
                        st_q <= TX_IDLE;
                    end
                end
                TX_SYM: if (tx_sym_ready) begin
                    valid_q <= 1'b0;
                    st_q <= TX_FETCH;
                end
                TX_PBYTE: if (txq_pop) begin // [RULE9]
                    byte_q <= head;
                    valid_q <= 1'b1;
                    kind_q <= pdfte_pkg::SYM_DATA;
                    nib_q <= head[3:0];
                    crc_q <= crc_nib(crc_q, head[3:0]);
                    st_q <= TX_LO;
                end
                TX_LO: if (tx_sym_ready) begin // [RULE9]
                    nib_q <= byte_q[7:4];
                    crc_q <= crc_nib(crc_q, byte_q[7:4]);
                    st_q <= TX_HI;
                end
                TX_HI: if (tx_sym_ready) begin
                    valid_q <= 1'b0;
                    cnt_q <= cnt_q - 5'h01;
                    st_q <= (cnt_q == 5'h01) ? TX_FETCH : TX_PBYTE;
                end
                TX_CRC: if (tx_sym_ready) begin // [RULE10]
                    if (crc_idx_q == pdfte_pkg::CRC_LAST) begin
                        valid_q <= 1'b0;
                        st_q <= TX_FETCH;
                    end else begin
                        crc_idx_q <= crc_idx_q + 3'h1;
                        nib_q <= crc_sh[3:0];
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receive queue
    // ------------------------------------------------------------
    logic [7:0] rxq_mem [RXQ_DEPTH];
    logic [RW-1:0] rxq_wr_q, rxq_rd_q;
    logic [RW:0] rxq_cnt_q;
    logic keep_q;
    logic [2:0] tag;
    logic tag_en;
    always_comb begin
        unique case (rx_sop_type)
            3'h1: begin tag = pdfte_pkg::TAG_PRIME; tag_en = ctrl_q[pdfte_pkg::CTRL_EN_PRIME]; end // [RULE15]
            3'h2: begin tag = pdfte_pkg::TAG_DPRIME; tag_en = ctrl_q[pdfte_pkg::CTRL_EN_PRIME + 1]; end // [RULE16]
            3'h3: begin tag = pdfte_pkg::TAG_PDBG; tag_en = ctrl_q[pdfte_pkg::CTRL_EN_PRIME + 2]; end // [RULE17]
            3'h4: begin tag = pdfte_pkg::TAG_DPDBG; tag_en = ctrl_q[pdfte_pkg::CTRL_EN_PRIME + 3]; end // [RULE18]
            3'h0: begin tag = pdfte_pkg::TAG_SOP; tag_en = 1'b1; end // [RULE14]
            default: begin tag = pdfte_pkg::TAG_SOP; tag_en = 1'b0; end
        endcase
    end
    wire rxq_empty = rxq_cnt_q == '0;
    wire rxq_full = rxq_cnt_q == (RW+1)'(RXQ_DEPTH); // [RULE13]
    // Bytes that find the queue full are lost; no back-pressure to the line
    wire rxq_push = ~rxq_full & ((rx_sop_valid & tag_en) | (~rx_sop_valid & rx_byte_valid & keep_q)); // [RULE23]
    wire [7:0] rxq_din = rx_sop_valid ? {tag, 5'h00} : rx_byte;
    wire rxq_pop = rd_fifo & ~rxq_empty; // [RULE20]

    always_ff @(posedge sys_clk) begin
        if (rxq_push) begin
            rxq_mem[rxq_wr_q] <= rxq_din;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rxq_wr_q <= '0;
            rxq_rd_q <= '0;
            rxq_cnt_q <= '0;
            keep_q <= 1'b0;
        end else begin
            if (rx_sop_valid) begin
                keep_q <= tag_en;
            end
            if (rxq_push) begin
                rxq_wr_q <= (rxq_wr_q == RW'(RXQ_DEPTH - 1)) ? '0 : rxq_wr_q + 1'b1;
            end
            if (rxq_pop) begin
                rxq_rd_q <= (rxq_rd_q == RW'(RXQ_DEPTH - 1)) ? '0 : rxq_rd_q + 1'b1;
            end
            rxq_cnt_q <= rxq_cnt_q + (RW+1)'(rxq_push) - (RW+1)'(rxq_pop);
        end
    end

    // ------------------------------------------------------------
    // Register file; read data captured in the setup cycle
    // ------------------------------------------------------------
    wire [31:0] stat_word = {24'h000000, drv_q, st_q != TX_IDLE, 2'b00, txq_full, txq_empty, rxq_full, rxq_empty};
    assign rd_mux = hit_fifo ? {24'h000000, rxq_empty ? 8'h00 : rxq_mem[rxq_rd_q]}
        : hit_ctrl ? {27'h0000000, ctrl_q[4:1], 1'b0}
        : hit_stat ? stat_word : 32'h00000000;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            prdata_q <= 32'h00000000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            ctrl_q <= pdfte_pkg::CTRL_RESET;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~hit_any;
            if (setup) begin
                prdata_q <= rd_mux;
            end
            if (wr_ctrl) begin
                ctrl_q <= {pwdata[4:1], 1'b0};
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign tx_sym_valid = valid_q;
    assign tx_sym_kind = kind_q;
    assign tx_nibble = nib_q;
    assign tx_drv_en = drv_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_start_no_queue;
        @(posedge sys_clk) disable iff (!rst_n) (wr_fifo && start_tok) |=> txq_cnt_q <= $past(txq_cnt_q);
    endproperty
    a_start_no_queue: assert property (p_start_no_queue) else $error("start token was queued"); // [RULE2]

    property p_start_runs;
        @(posedge sys_clk) disable iff (!rst_n) (start_cmd && st_q == TX_IDLE) |=> ##1 (st_q == TX_FETCH && drv_q);
    endproperty
    a_start_runs: assert property (p_start_runs) else $error("start did not run transmitter"); // [RULE2]

    property p_single_fetch;
        @(posedge sys_clk) disable iff (!rst_n) (st_q != TX_FETCH && st_q != TX_PBYTE) |=> $stable(txq_rd_q);
    endproperty
    a_single_fetch: assert property (p_single_fetch) else $error("fetch during symbol"); // [RULE1]

    property p_sync1;
        @(posedge sys_clk) disable iff (!rst_n)
            (st_q == TX_FETCH && txq_pop && head == pdfte_pkg::TOK_SYNC1) |=> valid_q && kind_q == pdfte_pkg::SYM_SYNC1;
    endproperty
    a_sync1: assert property (p_sync1) else $error("sync one not sent"); // [RULE5]

    property p_rst2;
        @(posedge sys_clk) disable iff (!rst_n)
            (st_q == TX_FETCH && txq_pop && head == pdfte_pkg::TOK_RST2) |=> valid_q && kind_q == pdfte_pkg::SYM_RST2;
    endproperty
    a_rst2: assert property (p_rst2) else $error("reset two not sent"); // [RULE6]

    property p_lo_first;
        @(posedge sys_clk) disable iff (!rst_n)
            (st_q == TX_PBYTE && txq_pop) |=> nib_q == $past(head[3:0]) ##0 (st_q == TX_LO);
    endproperty
    a_lo_first: assert property (p_lo_first) else $error("low nibble not first"); // [RULE9]

    property p_drv_off;
        @(posedge sys_clk) disable iff (!rst_n)
            (st_q == TX_FETCH && txq_pop && head == pdfte_pkg::TOK_OFF) |=> !drv_q && st_q == TX_IDLE;
    endproperty
    a_drv_off: assert property (p_drv_off) else $error("driver not off"); // [RULE12]

    property p_prime_gate;
        @(posedge sys_clk) disable iff (!rst_n)
            (rx_sop_valid && rx_sop_type == 3'h1 && !ctrl_q[pdfte_pkg::CTRL_EN_PRIME]) |=> $stable(rxq_wr_q);
    endproperty
    a_prime_gate: assert property (p_prime_gate) else $error("disabled prime stored"); // [RULE15]

    property p_sop_tag;
        @(posedge sys_clk) disable iff (!rst_n)
            (rxq_push && rx_sop_valid && rx_sop_type == 3'h0) |-> rxq_din[7:5] == pdfte_pkg::TAG_SOP;
    endproperty
    a_sop_tag: assert property (p_sop_tag) else $error("bad sop tag"); // [RULE14]
endmodule

// ===== verif/pdfte_line_model.sv
/*
 Line-side model of the token engine: takes transmit symbols, at once or
 with stalls, and plays tagged receive packets.
 Assumes the engine's clock and reset; the bench calls send_pkt.
*/
`timescale 1ns/10ps
module pdfte_line_model (
    // Clock, reset, pacing
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic slow,
    // Transmit symbols
    input wire logic tx_sym_valid,
    input wire logic [3:0] tx_sym_kind,
    input wire logic [3:0] tx_nibble,
    input wire logic tx_drv_en,
    output logic tx_sym_ready,
    // Receive packets
    output logic rx_sop_valid,
    output logic [2:0] rx_sop_type,
    output logic rx_byte_valid,
    output logic [7:0] rx_byte
);
    // ------------------------------------------------------------
    // Symbol capture
    // ------------------------------------------------------------
    logic [8:0] seen[$];
    initial begin
        tx_sym_ready = 1'b1;
        rx_sop_valid = 1'b0;
        rx_sop_type = 3'h0;
        rx_byte_valid = 1'b0;
        rx_byte = 8'h00;
    end
    // Stalls every other cycle when slow, to stretch each symbol
    always @(posedge sys_clk) begin
        if (rst_n && tx_sym_valid && tx_sym_ready) begin
            seen.push_back({tx_drv_en, tx_sym_kind, tx_nibble});
        end
        tx_sym_ready <= !slow || !tx_sym_ready;
    end
    // ------------------------------------------------------------
    // Packet player
    // ------------------------------------------------------------
    // Idle lines show inverted values so stale data never looks valid
    task automatic send_pkt(input logic [2:0] kind, input int n, input logic [7:0] b0);
        @(posedge sys_clk);
        rx_sop_valid <= 1'b1;
        rx_sop_type <= kind;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            rx_sop_valid <= 1'b0;
            rx_sop_type <= ~kind;
            rx_byte_valid <= 1'b1;
            rx_byte <= b0 + 8'(i);
        end
        @(posedge sys_clk);
        rx_sop_valid <= 1'b0;
        rx_byte_valid <= 1'b0;
        rx_byte <= ~(b0 + 8'(n - 1));
    endtask
endmodule

// ===== verif/tb.sv
/*
 Self-checking bench of the token engine: APB tasks, transmit token runs
 and receive tagging scenarios.
 Assumes pdfte_top and the line model beside it.
*/
`timescale 1ns/10ps
module tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [11:0] A_FIFO = {2'h0, pdfte_pkg::FIFO_IDX, 2'h0};
    localparam logic [11:0] A_CTRL = {2'h0, pdfte_pkg::CTRL_IDX, 2'h0};
    localparam logic [11:0] A_STAT = {2'h0, pdfte_pkg::STAT_IDX, 2'h0};
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, slow, serr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic tx_sym_valid, tx_sym_ready, tx_drv_en, rx_sop_valid, rx_byte_valid;
    logic [3:0] tx_sym_kind, tx_nibble;
    logic [2:0] rx_sop_type;
    logic [7:0] rx_byte;
    logic [8:0] exp_tx[$];
    logic [15:0] exp_rx[$];
    logic [2:0] tag_of[5] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3};
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;

    always #4 sys_clk = ~sys_clk;
    // Hang guard, far above the several hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            $display("ERROR at %0t: run too long", $time);
            final_report();
        end
    end

    pdfte_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .tx_sym_valid(tx_sym_valid), .tx_sym_kind(tx_sym_kind), .tx_nibble(tx_nibble),
        .tx_sym_ready(tx_sym_ready), .tx_drv_en(tx_drv_en), .rx_sop_valid(rx_sop_valid),
        .rx_sop_type(rx_sop_type), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte));
    pdfte_line_model line (.sys_clk(sys_clk), .rst_n(rst_n), .slow(slow), .tx_sym_valid(tx_sym_valid),
        .tx_sym_kind(tx_sym_kind), .tx_nibble(tx_nibble), .tx_drv_en(tx_drv_en),
        .tx_sym_ready(tx_sym_ready), .rx_sop_valid(rx_sop_valid), .rx_sop_type(rx_sop_type),
        .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Entered just after an edge; one idle cycle keeps transfers apart
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) begin
            err_total++;
            $display("ERROR at %0t: no pready", $time);
        end
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // Full packet queued first, then started inline or by control bit
    task automatic tx_run(input logic use_ctrl);
        logic [31:0] crc;
        logic [7:0] toks[$];
        int n;
        toks = '{8'h12, 8'h13, 8'h1b, 8'h15, 8'h16, 8'h82, 8'h3c, 8'h5a, 8'hff, 8'h14, 8'hfe};
        exp_tx = '{9'h100, 9'h110, 9'h120, 9'h130, 9'h140, 9'h16c, 9'h163, 9'h16a, 9'h165};
        crc = 32'hffffffff;
        for (int i = 5; i < 9; i++) begin
            crc ^= {28'h0, exp_tx[i][3:0]};
            repeat (4) crc = crc[0] ? (crc >> 1) ^ pdfte_pkg::CRC_POLY : crc >> 1;
        end
        crc = ~crc;
        for (int i = 0; i < 8; i++) exp_tx.push_back({5'h17, crc[4*i +: 4]});
        exp_tx.push_back(9'h150);
        line.seen.delete();
        foreach (toks[i]) wr(A_FIFO, toks[i]);
        if (use_ctrl) wr(A_CTRL, 8'h01); else wr(A_FIFO, 8'ha1);
        n = 0;
        do begin
            rd(A_STAT);
            n++;
        end while ((rdat[6] !== 1'b0 || line.seen.size() < exp_tx.size()) && n < 300);
        repeat (20) @(posedge sys_clk);
        check(rdat, 32'h05, "status after driver off");
        check(32'(line.seen.size()), 32'(exp_tx.size()), "symbol count");
        foreach (exp_tx[i]) check({23'h0, line.seen[i]}, {23'h0, exp_tx[i]}, "symbol");
    endtask

    task automatic expect_pkt(input int t, input int n, input logic [7:0] b0);
        exp_rx.push_back({8'he0, tag_of[t], 5'h0});
        for (int i = 0; i < n; i++) exp_rx.push_back({8'hff, b0 + 8'(i)});
    endtask

    task automatic drain_rx();
        while (exp_rx.size() > 0) begin
            rd(A_FIFO);
            check(rdat & {24'h0, exp_rx[0][15:8]}, {24'h0, exp_rx[0][7:0]}, "rx byte");
            void'(exp_rx.pop_front());
        end
        rd(A_STAT);
        check({31'h0, rdat[0]}, 32'h1, "rx empty");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        slow = 1'b0;
        repeat (6) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(A_STAT);
        check(rdat, 32'h05, "status after reset");
        rd(12'h3fc);
        check({31'h0, serr}, 32'h1, "unmapped error");
        check(rdat, 32'h0, "unmapped data");
        tx_run(1'b0);
        slow <= 1'b1;
        tx_run(1'b1);
        slow <= 1'b0;
        wr(A_CTRL, 8'h02);
        for (int t = 0; t < 5; t++) line.send_pkt(3'(t), 2, 8'(16 * t));
        wr(A_CTRL, 8'h1c);
        for (int t = 1; t < 5; t++) line.send_pkt(3'(t), 2, 8'(16 * t));
        for (int t = 0; t < 5; t++) expect_pkt(t, 2, 8'(16 * t));
        drain_rx();
        line.send_pkt(3'h0, 79, 8'h00);
        rd(A_STAT);
        check({30'h0, rdat[1:0]}, 32'h2, "rx full");
        line.send_pkt(3'h0, 3, 8'h90);
        expect_pkt(0, 79, 8'h00);
        drain_rx();
        final_report();
    end
endmodule
